/* File: shared/psdr_defs.svh */
// constants for the processor status and debug register bank
//
// Functional notes
// - three read-only 16-bit oscillator count registers
// - oscillator counts survive system reset
// - memory size in bits 31:2, low bits reserved
// - capture status word on debugger entry
// - status bits 0-4 hold enable and mode flags
// - bits 6,7 pause and fast; bit 8 read-only
// - bit 9 kernel issue mode, bit 10 space id
// - capture 32-bit program counter on debugger entry
// - capture 32-bit stack pointer on debugger entry
// - 8-bit thread select operand for register read
// - 5-bit register select operand, upper bits reserved
// - 3-bit entry cause code, reset to zero
// - 2-bit breakpoint number, lowest wins, zero otherwise
// - 8-bit cause thread number, zero for host
`ifndef PSDR_DEFS_SVH
`define PSDR_DEFS_SVH

// register indices; byte address is four times the index
`define PSDR_IDX_TILE_WIRE_OSC   8'h08
`define PSDR_IDX_PERIPH_CELL_OSC 8'h09
`define PSDR_IDX_PERIPH_WIRE_OSC 8'h0A
`define PSDR_IDX_MEMORY_SIZE     8'h0C
`define PSDR_IDX_SAVED_STATUS    8'h10
`define PSDR_IDX_SAVED_PC        8'h11
`define PSDR_IDX_SAVED_SP        8'h12
`define PSDR_IDX_THREAD_SEL      8'h13
`define PSDR_IDX_REG_SEL         8'h14
`define PSDR_IDX_ENTRY_CAUSE     8'h15
`define PSDR_IDX_IRQ_STATUS      8'h1C
`define PSDR_IDX_IRQ_MASK        8'h1D

// field layouts
`define PSDR_OSC_W        16
`define PSDR_SSR_W        11
`define PSDR_SSR_RSVD_BIT 5
`define PSDR_SSR_RO_BIT   8
`define PSDR_SSR_WMASK    11'h6DF
`define PSDR_TSEL_W       8
`define PSDR_RSEL_W       5
`define PSDR_CAUSE_W      3
`define PSDR_BPNUM_W      2
`define PSDR_TNUM_W       8
`define PSDR_TNUM_LSB     8
`define PSDR_BPNUM_LSB    16
`define PSDR_MEM_LSB      2
`define PSDR_IRQ_W        2

// entry cause codes
`define PSDR_CAUSE_NONE   3'h0
`define PSDR_CAUSE_HOST   3'h1
`define PSDR_CAUSE_DEBUG_CALL_INSTR  3'h2
`define PSDR_CAUSE_IBRK   3'h3
`define PSDR_CAUSE_DWATCH 3'h4
`define PSDR_CAUSE_RWATCH 3'h5

// interrupt status bit positions
`define PSDR_IRQ_ENTRY_BIT 0
`define PSDR_IRQ_OSC_BIT   1

`define PSDR_ZERO32 32'h0000_0000

`endif

/* File: shared/psdr_pkg.sv */
// types shared by the processor status and debug register bank
package psdr_pkg;

	// state captured when the debugger is entered
	typedef struct packed {
		logic [10:0] status;   // saved status word
		logic [31:0] pc;       // saved program counter
		logic [31:0] sp;       // saved stack pointer
		logic [2:0]  cause;    // entry cause code
		logic [3:0]  bp_hit;   // breakpoints that fired, one bit each
		logic [7:0]  thread;   // thread that raised the entry
	} psdr_entry_t;

	// register bus request
	typedef struct packed {
		logic [7:0]  addr;     // register index
		logic [31:0] wdata;    // write data
		logic        wr;       // write strobe
		logic        rd;       // read strobe
	} psdr_bus_t;

	// bank state machine for the debug session
	typedef enum logic [0:0] {
		PSDR_RUN,
		PSDR_DEBUG
	} psdr_mode_t;

endpackage : psdr_pkg

/* File: rtl/psdr_regs.sv */
// processor status and debug register bank for one tile
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "psdr_defs.svh"

module psdr_regs (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire psdr_pkg::psdr_bus_t  bus,
	output logic [31:0]               rdata,
	input  wire logic                 osc_tile_wire_ena,
	input  wire logic                 osc_periph_cell_ena,
	input  wire logic                 osc_periph_wire_ena,
	input  wire logic                 osc_tile_wire_tick,
	input  wire logic                 osc_periph_cell_tick,
	input  wire logic                 osc_periph_wire_tick,
	input  wire logic [29:0]          ram_size_words,
	input  wire logic                 debug_enter,
	input  wire logic                 debug_exit,
	input  wire psdr_pkg::psdr_entry_t entry,
	output logic                      debug_mode,
	output logic [7:0]                read_thread_number,
	output logic [4:0]                read_register_number,
	output logic                      irq
);

	// oscillator tick synchronisers; ticks arrive from free-running rings
	logic [2:0] tick_s1_q;   // first stage, read only by second stage
	logic [2:0] tick_s2_q;   // second stage
	logic [2:0] tick_s3_q;   // edge-detect history
	logic [2:0] ena_s1_q;    // enable first stage
	logic [2:0] ena_s2_q;    // enable second stage

	// counters
	logic [`PSDR_OSC_W-1:0] osc_cnt_q [3] = '{default: '0};   // power-up zero, rst_n never clears

	// captured debug state
	logic [`PSDR_SSR_W-1:0]   saved_status_word_q;
	logic [31:0]              saved_program_counter_q;
	logic [31:0]              saved_stack_pointer_q;
	logic [`PSDR_TSEL_W-1:0]  tsel_q;
	logic [`PSDR_RSEL_W-1:0]  rsel_q;
	logic [`PSDR_CAUSE_W-1:0] entry_cause_code_q;
	logic [`PSDR_BPNUM_W-1:0] bp_num_q;
	logic [`PSDR_TNUM_W-1:0]  cause_thread_number_q;
	logic [29:0]              mem_words_q;
	logic [`PSDR_IRQ_W-1:0]   irq_status_q;
	logic [`PSDR_IRQ_W-1:0]   irq_mask_q;
	psdr_pkg::psdr_mode_t     mode_q;
	logic [2:0]               ena_prev_q;   // enable history for stop events

	logic [`PSDR_IRQ_W-1:0] irq_event;   // events this cycle
	logic                   dbg_wr;      // write allowed to debug fields

	// lowest-numbered fired breakpoint wins
	function automatic logic [`PSDR_BPNUM_W-1:0] lowest_hit(input logic [3:0] hits);
		logic [`PSDR_BPNUM_W-1:0] n;
		n = 2'h0;
		for (int i = 3; i >= 0; i--)
		begin
			if (hits[i])
				n = 2'(i);
		end
		return n;
	endfunction : lowest_hit

	// write strobe aimed at one register index
	function automatic logic hit(input psdr_pkg::psdr_bus_t b, input logic [7:0] idx);
		return b.wr && (b.addr == idx);
	endfunction : hit

	// debug-mode writes only; outside debug mode they drop silently
	assign dbg_wr = (mode_q == psdr_pkg::PSDR_DEBUG) && !debug_enter;

	// two-flop synchronisers for ticks and enables
	always_ff @(posedge mclk)
	begin
		tick_s1_q <= {osc_periph_wire_tick, osc_periph_cell_tick, osc_tile_wire_tick};
		tick_s2_q <= tick_s1_q;
		tick_s3_q <= tick_s2_q;
		ena_s1_q  <= {osc_periph_wire_ena, osc_periph_cell_ena, osc_tile_wire_ena};
		ena_s2_q  <= ena_s1_q;
		ena_prev_q <= ena_s2_q;
	end

	// counters carry no reset so the count survives a system reset
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (ena_s2_q[i] && tick_s2_q[i] && !tick_s3_q[i])
				osc_cnt_q[i] <= osc_cnt_q[i] + 16'h0001;
		end
	end

	// memory size sampled every cycle, with no reset, so also while under reset
	always_ff @(posedge mclk)
	begin
		mem_words_q <= ram_size_words;
	end

	// debug session state
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			mode_q <= psdr_pkg::PSDR_RUN;
		else
		begin
			unique case (mode_q)
				psdr_pkg::PSDR_RUN:
				begin
					if (debug_enter)
						mode_q <= psdr_pkg::PSDR_DEBUG;
				end
				psdr_pkg::PSDR_DEBUG:
				begin
					if (debug_exit)
						mode_q <= psdr_pkg::PSDR_RUN;
				end
			endcase
		end
	end

	// saved status, pc and sp: captured on entry, debug-writable after
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			saved_status_word_q     <= 11'h000;
			saved_program_counter_q <= `PSDR_ZERO32;
			saved_stack_pointer_q   <= `PSDR_ZERO32;
		end
		else if (debug_enter && mode_q == psdr_pkg::PSDR_RUN)
		begin
			saved_status_word_q     <= entry.status & ~(11'(1) << `PSDR_SSR_RSVD_BIT);
			saved_program_counter_q <= entry.pc;
			saved_stack_pointer_q   <= entry.sp;
		end
		else if (dbg_wr)
		begin
			// bit 8 and bit 5 keep their value; only the writable mask moves
			if (hit(bus, `PSDR_IDX_SAVED_STATUS))
				saved_status_word_q <= (saved_status_word_q & ~`PSDR_SSR_WMASK)
					| (bus.wdata[`PSDR_SSR_W-1:0] & `PSDR_SSR_WMASK);
			if (hit(bus, `PSDR_IDX_SAVED_PC))
				saved_program_counter_q <= bus.wdata;
			if (hit(bus, `PSDR_IDX_SAVED_SP))
				saved_stack_pointer_q <= bus.wdata;
		end
	end

	// register-read operands written by debug software
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			tsel_q <= 8'h00;
			rsel_q <= 5'h00;
		end
		else if (dbg_wr)
		begin
			if (hit(bus, `PSDR_IDX_THREAD_SEL))
				tsel_q <= bus.wdata[`PSDR_TSEL_W-1:0];
			if (hit(bus, `PSDR_IDX_REG_SEL))
				rsel_q <= bus.wdata[`PSDR_RSEL_W-1:0];
		end
	end

	// entry cause record
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			entry_cause_code_q    <= `PSDR_CAUSE_NONE;
			bp_num_q              <= 2'h0;
			cause_thread_number_q <= 8'h00;
		end
		else if (debug_enter && mode_q == psdr_pkg::PSDR_RUN)
		begin
			entry_cause_code_q <= entry.cause;
			// host and debug-call entries carry no breakpoint number
			if (entry.cause == `PSDR_CAUSE_HOST || entry.cause == `PSDR_CAUSE_DEBUG_CALL_INSTR)
				bp_num_q <= 2'h0;
			else
				bp_num_q <= lowest_hit(entry.bp_hit);
			// host entries name no thread
			if (entry.cause == `PSDR_CAUSE_HOST)
				cause_thread_number_q <= 8'h00;
			else
				cause_thread_number_q <= entry.thread;
		end
		else if (dbg_wr && hit(bus, `PSDR_IDX_ENTRY_CAUSE))
		begin
			entry_cause_code_q    <= bus.wdata[`PSDR_CAUSE_W-1:0];
			cause_thread_number_q <= bus.wdata[`PSDR_TNUM_LSB +: `PSDR_TNUM_W];
			bp_num_q              <= bus.wdata[`PSDR_BPNUM_LSB +: `PSDR_BPNUM_W];
		end
	end

	// events: debug entry, and an oscillator stop (count already stable once the synchronised enable falls)
	assign irq_event[`PSDR_IRQ_ENTRY_BIT] = debug_enter && mode_q == psdr_pkg::PSDR_RUN;
	assign irq_event[`PSDR_IRQ_OSC_BIT]   = |(ena_prev_q & ~ena_s2_q);

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_status_q <= 2'h0;
		else if (hit(bus, `PSDR_IDX_IRQ_STATUS))
			irq_status_q <= (irq_status_q & ~bus.wdata[`PSDR_IRQ_W-1:0]) | irq_event;
		else
			irq_status_q <= irq_status_q | irq_event;
	end

	// interrupt mask
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_mask_q <= 2'h0;
		else if (hit(bus, `PSDR_IDX_IRQ_MASK))
			irq_mask_q <= bus.wdata[`PSDR_IRQ_W-1:0];
	end

	// registered outputs
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			irq                  <= 1'b0;
			debug_mode           <= 1'b0;
			read_thread_number   <= 8'h00;
			read_register_number <= 5'h00;
		end
		else
		begin
			// one cycle behind the status, accepted to keep the output registered
			irq                  <= |(irq_status_q & irq_mask_q);
			debug_mode           <= (mode_q == psdr_pkg::PSDR_DEBUG);
			read_thread_number   <= tsel_q;
			read_register_number <= rsel_q;
		end
	end

	// read data one cycle after the read strobe, zero otherwise
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !bus.rd)
			rdata <= `PSDR_ZERO32;
		else
		begin
			unique case (bus.addr)
				`PSDR_IDX_TILE_WIRE_OSC:   rdata <= {16'h0000, osc_cnt_q[0]};
				`PSDR_IDX_PERIPH_CELL_OSC: rdata <= {16'h0000, osc_cnt_q[1]};
				`PSDR_IDX_PERIPH_WIRE_OSC: rdata <= {16'h0000, osc_cnt_q[2]};
				`PSDR_IDX_MEMORY_SIZE:     rdata <= {mem_words_q, 2'h0};
				`PSDR_IDX_SAVED_STATUS:    rdata <= {21'h000000, saved_status_word_q};
				`PSDR_IDX_SAVED_PC:        rdata <= saved_program_counter_q;
				`PSDR_IDX_SAVED_SP:        rdata <= saved_stack_pointer_q;
				`PSDR_IDX_THREAD_SEL:      rdata <= {24'h000000, tsel_q};
				`PSDR_IDX_REG_SEL:         rdata <= {27'h0000000, rsel_q};
				`PSDR_IDX_ENTRY_CAUSE:
					rdata <= {14'h0000, bp_num_q, cause_thread_number_q,
						5'h00, entry_cause_code_q};
				`PSDR_IDX_IRQ_STATUS:      rdata <= {30'h00000000, irq_status_q};
				`PSDR_IDX_IRQ_MASK:        rdata <= {30'h00000000, irq_mask_q};
				default:                   rdata <= `PSDR_ZERO32;   // unmapped reads zero
			endcase
		end
	end

endmodule : psdr_regs

/* File: bench/psdr_regs_assertions.sv */
// concurrent checks on the ports of the status and debug register bank
`timescale 1ns/1ps
module psdr_regs_assertions (
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire psdr_pkg::psdr_bus_t bus,
	input wire logic [31:0]         rdata,
	input wire logic [29:0]         ram_size_words,
	input wire logic                debug_enter,
	input wire logic                debug_exit,
	input wire logic                debug_mode,
	input wire logic [7:0]          read_thread_number,
	input wire logic [4:0]          read_register_number
);
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_OSC_RSVD: assert property (bus.rd && bus.addr inside {8'h08, 8'h09, 8'h0A}
		|=> rdata[31:16] == 16'h0000) else $error("osc upper bits set");
	// size is registered each cycle, so the read shows the value two edges back
	AST_MEM_SIZE: assert property (bus.rd && bus.addr == 8'h0C
		|=> rdata == {$past(ram_size_words, 2), 2'b00}) else $error("memory size wrong");
	AST_SSR_RSVD: assert property (bus.rd && bus.addr == 8'h10
		|=> rdata[31:11] == 21'h0 && !rdata[5]) else $error("status reserved bits set");
	AST_TSEL: assert property (bus.rd && bus.addr == 8'h13
		|=> rdata == {24'h0, read_thread_number}) else $error("thread select mismatch");
	AST_RSEL: assert property (bus.rd && bus.addr == 8'h14
		|=> rdata == {27'h0, read_register_number}) else $error("register select mismatch");
	AST_CAUSE: assert property (bus.rd && bus.addr == 8'h15
		|=> rdata[31:18] == 14'h0 && rdata[7:3] == 5'h0 && rdata[2:0] <= 3'h5)
		else $error("cause field out of range");
	// a write while running must leave the operand alone
	AST_RUN_WR: assert property (!debug_mode && !$past(debug_enter) && bus.wr
		&& bus.addr == 8'h13 |=> ##1 $stable(read_thread_number))
		else $error("write accepted outside debug");
	AST_ENTER: assert property (debug_enter && !debug_mode && !$past(debug_enter)
		&& !debug_exit |-> ##2 debug_mode) else $error("debug entry not taken");
	AST_EXIT: assert property (debug_exit && debug_mode && !debug_enter
		|-> ##2 !debug_mode) else $error("debug exit not taken");
	cover property (debug_enter && !debug_mode);
	cover property (bus.rd && bus.addr == 8'h15);
	cover property (bus.wr && debug_mode && bus.addr == 8'h13);
endmodule : psdr_regs_assertions

/* File: bench/psdr_regs_tb.sv */
// self-checking bench for the status and debug register bank
`timescale 1ns/1ps
`include "psdr_defs.svh"
module psdr_regs_tb;
	logic                  mclk = 1'b0;
	logic                  rst_n = 1'b0;
	psdr_pkg::psdr_bus_t   bus = '0;
	logic [31:0]           rdata;
	logic [2:0]            ena = 3'h0;    // oscillator enables
	logic [2:0]            tick = 3'h0;   // oscillator outputs
	logic [29:0]           ram = 30'h0000_4000;
	logic                  d_in = 1'b0;
	logic                  d_out = 1'b0;
	psdr_pkg::psdr_entry_t ent = '0;
	logic                  dmode;
	logic [7:0]            tnum;
	logic [4:0]            rnum;
	logic                  irq;
	logic [1:0]            fl;            // irq and mode seen during last read
	logic [31:0]           v;
	logic [31:0]           v0;
	int                    fails = 0;
	int                    n_tests = 0;
	int                    cyc = 0;

	always #5 mclk = ~mclk;

	// cycle ceiling: the whole run needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fails = fails + 1;
			test_done();
		end
	end

	task test_done();
		$display("counts: fails %0d checks %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one-cycle write strobe, then one idle cycle so the bus is never set twice
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '0;
		@(posedge mclk);
	endtask : wr

	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [31:0] d);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus <= '0;
		@(negedge mclk);
		d = rdata;
		fl = {irq, dmode};
		@(posedge mclk);
	endtask : rd

	task pulse_enter(input logic [2:0] c, input logic [31:0] pc);
		ent <= '{status: 11'h7FF, pc: pc, sp: ~pc, cause: c, bp_hit: 4'b1100, thread: 8'h2A};
		d_in <= 1'b1;
		@(posedge mclk);
		d_in <= 1'b0;
		@(posedge mclk);
	endtask : pulse_enter

	task pulse_exit();
		d_out <= 1'b1;
		@(posedge mclk);
		d_out <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : pulse_exit

	// reset values, read-only and unmapped places, writes while running
	task t_reg();
		rd(8'h15, v);
		chk("cause", {29'h0, v[2:0]}, 32'h0);
		rd(8'h0B, v);
		chk("unmapped", v, 32'h0);
		wr(8'h0C, 32'hFFFF_FFFF);
		rd(8'h0C, v);
		chk("memsize", v, {ram, 2'b00});
		wr(8'h13, 32'h0000_0055);
		rd(8'h13, v);
		chk("tsel run", v, 32'h0);
		$display("done reg");
	endtask : t_reg

	// count known edges per oscillator, stop, settle, read; the periph wire count outlives reset
	task t_osc();
		for (int i = 0; i < 3; i++)
		begin
			rd(8'h08 + 8'(i), v0);
			chk("osc init", v0, 32'h0);
			ena[i] <= 1'b1;
			repeat (3) @(posedge mclk);
			for (int k = 0; k < 2 * i + 6; k++)
			begin
				tick[i] <= ~tick[i];
				repeat (2) @(posedge mclk);
			end
			ena[i] <= 1'b0;
			repeat (12) @(posedge mclk);
			rd(8'h08 + 8'(i), v);
			chk("osc", v, {16'h0, v0[15:0] + 16'(i + 3)});
		end
		v0 = v;
		chk("irq masked", {30'h0, fl}, 32'h0);
		wr(8'h1D, 32'h2);
		rd(8'h1C, v);
		chk("irq on", {v[1:0], fl}, 32'hA);
		wr(8'h1C, 32'h2);
		rd(8'h1C, v);
		chk("irq clr", {v[1:0], fl}, 32'h0);
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(8'h0A, v);
		chk("osc kept", v, v0);
		$display("done osc");
	endtask : t_osc

	// capture on entry, operand writes, read-only bit, cause codes 1 to 5
	task t_dbg();
		wr(8'h1D, 32'h1);
		pulse_enter(3'h4, 32'h1234_5678);
		rd(8'h10, v);
		chk("status", {v[29:0], fl}, {30'h7DF, 2'b11});
		pulse_enter(3'h1, 32'h0);
		rd(8'h11, v);
		chk("pc", v, 32'h1234_5678);
		rd(8'h12, v);
		chk("sp", v, 32'hEDCB_A987);
		wr(8'h11, 32'h0F0F_1234);
		rd(8'h11, v);
		chk("pc wr", v, 32'h0F0F_1234);
		wr(8'h13, 32'hFFFF_FFFF);
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h13, v);
		chk("tsel", {v[15:0], tnum}, 24'hFF_FF);
		rd(8'h14, v);
		chk("rsel", {v[15:0], 3'h0, rnum}, 24'h1F_1F);
		wr(8'h10, 32'h0);
		rd(8'h10, v);
		chk("status ro", v, 32'h100);
		wr(8'h1C, 32'h1);
		pulse_exit();
		wr(8'h13, 32'h0);
		rd(8'h13, v);
		chk("tsel kept", {v[29:0], fl}, {30'hFF, 2'b00});
		for (int c = 1; c < 6; c++)
		begin
			pulse_enter(3'(c), 32'(c));
			rd(8'h15, v);
			v0 = {14'h0, c > 2 ? 2'h2 : 2'h0, c == 1 ? 8'h0 : 8'h2A, 5'h0, 3'(c)};
			chk("type", v, v0);
			pulse_exit();
		end
		$display("done dbg");
	endtask : t_dbg

	initial
	begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_reg();
		t_osc();
		t_dbg();
		test_done();
	end

	psdr_regs i_dut (
		.mclk                 (mclk),
		.rst_n                (rst_n),
		.bus                  (bus),
		.rdata                (rdata),
		.osc_tile_wire_ena    (ena[0]),
		.osc_periph_cell_ena  (ena[1]),
		.osc_periph_wire_ena  (ena[2]),
		.osc_tile_wire_tick   (tick[0]),
		.osc_periph_cell_tick (tick[1]),
		.osc_periph_wire_tick (tick[2]),
		.ram_size_words       (ram),
		.debug_enter          (d_in),
		.debug_exit           (d_out),
		.entry                (ent),
		.debug_mode           (dmode),
		.read_thread_number   (tnum),
		.read_register_number (rnum),
		.irq                  (irq)
	);
endmodule : psdr_regs_tb

bind psdr_regs psdr_regs_assertions i_chk (.mclk(mclk), .rst_n(rst_n), .bus(bus),
	.rdata(rdata), .ram_size_words(ram_size_words), .debug_enter(debug_enter),
	.debug_exit(debug_exit), .debug_mode(debug_mode),
	.read_thread_number(read_thread_number), .read_register_number(read_register_number));
